/* alert_host_model.sv */
module alert_host_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // alert line from the charger
    input wire logic alertPulse,
    // what the host has seen
    output int alertCount,
    output int lastWidth
);
    timeunit 1ns;
    timeprecision 100ps;
    int run;
    ////////////////////////////////////////////////////////////////
    // a pulse is reported only once it ends, so a stuck line never counts
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alertCount <= 0;
            lastWidth <= 0;
            run <= 0;
        end else if (alertPulse === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            alertCount <= alertCount + 1;
            lastWidth <= run;
            run <= 0;
        end
    end
endmodule

/* alert_pulser.sv */
module alert_pulser
    import charger_fault_pkg::*;
#(
    parameter int PULSE_CYCLES = ALERT_PULSE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // request and output
    input wire logic trigger,
    output logic alertPulse
);
    typedef struct packed {
        logic [ALERT_CNT_W-1:0] cnt;
        logic pulse;
    } pulser_t;

    pulser_t state_q;
    pulser_t state_d;

    // a trigger during a running pulse is merged: one pulse per burst, never stretched
    always_comb begin
        state_d = state_q;
        if (state_q.pulse) begin
            if (state_q.cnt == ALERT_CNT_ONE) begin
                state_d.pulse = 1'b0;
                state_d.cnt = ALERT_CNT_ZERO;
            end else begin
                state_d.cnt = state_q.cnt - ALERT_CNT_ONE;
            end
        end else if (trigger) begin
            state_d.pulse = 1'b1;
            state_d.cnt = ALERT_CNT_W'(PULSE_CYCLES);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign alertPulse = state_q.pulse;
endmodule

/* charger_fault_pkg.sv */
package charger_fault_pkg;
    // charge-state field encodings
    localparam logic [1:0] CHG_READY = 2'h0;
    localparam logic [1:0] CHG_IN_PROGRESS = 2'h1;
    localparam logic [1:0] CHG_DONE = 2'h2;
    localparam logic [1:0] CHG_FAULT = 2'h3;
    // thermistor zone codes, as reported by the sensing front end
    localparam logic [2:0] ZONE_NORMAL = 3'h0;
    localparam logic [2:0] ZONE_COLD = 3'h1;
    localparam logic [2:0] ZONE_COOL = 3'h2;
    localparam logic [2:0] ZONE_WARM = 3'h3;
    localparam logic [2:0] ZONE_HOT = 3'h4;
    // warm-zone regulation offset
    localparam int WARM_DROP_MV = 140;
    // alert pulse timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ALERT_PULSE_US = 128;
    localparam int ALERT_PULSE_CYCLES = (ALERT_PULSE_US * 1000) / CLK_PERIOD_NS;
    localparam int ALERT_CNT_W = 15;
    localparam logic [ALERT_CNT_W-1:0] ALERT_CNT_ZERO = 15'h0000;
    localparam logic [ALERT_CNT_W-1:0] ALERT_CNT_ONE = 15'h0001;
endpackage

/* charger_fault_response_control.sv */
// Summary of operation
// [R1] input overvoltage: flag, fault state, alert, no supply ok, charger and sensing off
// [R2] input undervoltage: flag, fault state, alert, no supply ok, charger and sensing off
// [R3] input current clamp: charge on with clamped input, in progress, alert
// [R4] input voltage regulation: flag, fault state, alert, charge with reduced input
// [R5] safety timer expiry: timer flag, fault state, alert, charger and sensing off
// [R6] cold or hot zone: record zone, fault state, alert, charger off
// [R7] cool zone: record cool, fault state, alert, charge current halved
// [R8] warm zone: record warm, fault state, alert, regulation voltage lowered 140 mV
// [R9] charge done: done state, alert, charger off, watch recharge threshold
// [R10] each alert is one active pulse of 128 us
// [R11] concurrent conditions: disabled beats reduced, reduced beats enabled, per output
module charger_fault_response_control
    import charger_fault_pkg::*;
#(
    parameter int PULSE_CYCLES = ALERT_PULSE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // condition inputs from analog supervisors
    input wire logic inputOvervoltage,
    input wire logic inputUndervoltage,
    input wire logic inputCurrentClamp,
    input wire logic inputVoltageRegulation,
    input wire logic safetyTimerExpired,
    input wire logic chargeComplete,
    input wire logic [2:0] thermistorZone,
    // configured enables
    input wire logic sysRailEnableCfg,
    input wire logic loadOutputEnableCfg,
    // status
    output logic [1:0] chargeState,
    output logic input_overvoltage_flag,
    output logic input_undervoltage_flag,
    output logic input_voltage_regulation_flag,
    output logic safetyTimerFault,
    output logic [2:0] thermistor_zone_fault,
    output logic supply_ok_output,
    // alert to host
    output logic alertPulse,
    // power path controls
    output logic chargerEnable,
    output logic inputCurrentClamped,
    output logic inputCurrentReduced,
    output logic chargeCurrentHalved,
    output logic regulationVoltageLowered,
    output logic rechargeWatch,
    output logic thermistorSenseEnable,
    output logic sysRailEnable,
    output logic sysRailFromBattery,
    output logic loadOutputEnable,
    output logic loadOutputFromBattery
);
    typedef struct packed {
        logic [1:0] chg;
        logic ov;
        logic uv;
        logic vreg;
        logic tmr;
        logic [2:0] zone;
        logic pg;
        logic chgEn;
        logic clamp;
        logic reduce;
        logic half;
        logic lower;
        logic watch;
        logic tsEn;
        logic sysEn;
        logic sysBat;
        logic lsEn;
        logic lsBat;
        logic [6:0] evPrev;
    } ctl_t;

    ctl_t state_q;
    ctl_t state_d;
    logic coldHot;
    logic cool;
    logic warm;
    logic [6:0] events;
    logic alertTrig;

    assign coldHot = (thermistorZone == ZONE_COLD) || (thermistorZone == ZONE_HOT);
    assign cool = (thermistorZone == ZONE_COOL);
    assign warm = (thermistorZone == ZONE_WARM);
    assign events = {chargeComplete, warm, cool, coldHot, safetyTimerExpired,
                     inputVoltageRegulation | inputCurrentClamp,
                     inputOvervoltage | inputUndervoltage};
    // alert fires on the rising edge of any event bit (over/undervoltage share one, as do regulation and clamp) so a held level alerts once
    assign alertTrig = |(events & ~state_q.evPrev);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic vinBad;
        logic faultAny;
        vinBad = 1'b0;
        faultAny = 1'b0;
        state_d = state_q;
        vinBad = inputOvervoltage | inputUndervoltage;
        faultAny = vinBad | inputVoltageRegulation | safetyTimerExpired
                   | coldHot | cool | warm;
        state_d.evPrev = events;
        state_d.ov = inputOvervoltage; // [R1]
        state_d.uv = inputUndervoltage; // [R2]
        state_d.vreg = inputVoltageRegulation; // [R4]
        state_d.tmr = safetyTimerExpired; // [R5]
        state_d.zone = (coldHot | cool | warm) ? thermistorZone : ZONE_NORMAL; // [R6] [R7] [R8]
        state_d.pg = !vinBad; // [R1] [R2]
        // fault outranks done and in-progress in the status field
        if (faultAny) begin
            state_d.chg = CHG_FAULT; // [R1] [R2] [R4] [R5] [R6] [R7] [R8]
        end else if (chargeComplete) begin
            state_d.chg = CHG_DONE; // [R9]
        end else if (inputCurrentClamp) begin
            state_d.chg = CHG_IN_PROGRESS; // [R3]
        end else begin
            state_d.chg = CHG_READY;
        end
        // disabled wins over any reduction
        state_d.chgEn = !(vinBad | safetyTimerExpired | coldHot | chargeComplete); // [R11]
        state_d.clamp = state_d.chgEn & inputCurrentClamp; // [R3] [R11]
        state_d.reduce = state_d.chgEn & inputVoltageRegulation; // [R4] [R11]
        state_d.half = state_d.chgEn & cool; // [R7] [R11]
        state_d.lower = state_d.chgEn & warm; // [R8] [R11]
        state_d.watch = chargeComplete & !vinBad; // [R9]
        state_d.tsEn = !(vinBad | safetyTimerExpired); // [R1] [R2] [R5] [R11]
        // on a bad input the rails are held up from the battery
        state_d.sysEn = vinBad | sysRailEnableCfg; // [R1] [R2] [R3]
        state_d.sysBat = vinBad; // [R1] [R2]
        state_d.lsEn = vinBad | loadOutputEnableCfg; // [R1] [R2] [R3]
        state_d.lsBat = vinBad; // [R1] [R2]
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    alert_pulser #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) u_alert (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .trigger(alertTrig), // [R10]
        .alertPulse(alertPulse)
    );

    assign chargeState = state_q.chg;
    assign input_overvoltage_flag = state_q.ov;
    assign input_undervoltage_flag = state_q.uv;
    assign input_voltage_regulation_flag = state_q.vreg;
    assign safetyTimerFault = state_q.tmr;
    assign thermistor_zone_fault = state_q.zone;
    assign supply_ok_output = state_q.pg;
    assign chargerEnable = state_q.chgEn;
    assign inputCurrentClamped = state_q.clamp;
    assign inputCurrentReduced = state_q.reduce;
    assign chargeCurrentHalved = state_q.half;
    assign regulationVoltageLowered = state_q.lower;
    assign rechargeWatch = state_q.watch;
    assign thermistorSenseEnable = state_q.tsEn;
    assign sysRailEnable = state_q.sysEn;
    assign sysRailFromBattery = state_q.sysBat;
    assign loadOutputEnable = state_q.lsEn;
    assign loadOutputFromBattery = state_q.lsBat;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_ovRise;
        inputOvervoltage && !state_q.evPrev[0];
    endsequence
    // the pulse starts on the edge that samples the rise, so it reads high one cycle later
    sequence s_alertStart;
        !alertPulse ##1 alertPulse;
    endsequence

    AST_OV_RESP: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
        inputOvervoltage |=> (!chargerEnable && !supply_ok_output && input_overvoltage_flag
                              && chargeState == CHG_FAULT && sysRailFromBattery))
        else $error("overvoltage response wrong");
    AST_OV_ALERT: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
        (s_ovRise and (!alertPulse)) |-> s_alertStart)
        else $error("overvoltage did not alert");
    AST_UV_RESP: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
        inputUndervoltage |=> (!thermistorSenseEnable && input_undervoltage_flag
                               && loadOutputEnable && !supply_ok_output))
        else $error("undervoltage response wrong");
    AST_CLAMP: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
        (inputCurrentClamp && !chargeComplete && !safetyTimerExpired && thermistorZone
         == ZONE_NORMAL && !inputOvervoltage && !inputUndervoltage && !inputVoltageRegulation)
        |=> (chargerEnable && inputCurrentClamped && chargeState == CHG_IN_PROGRESS))
        else $error("clamp response wrong");
    AST_VREG: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
        inputVoltageRegulation |=> (input_voltage_regulation_flag && chargeState == CHG_FAULT))
        else $error("regulation response wrong");
    AST_TIMER: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
        safetyTimerExpired |=> (safetyTimerFault && !chargerEnable && !thermistorSenseEnable))
        else $error("timer response wrong");
    AST_COLD_HOT: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
        coldHot |=> (!chargerEnable && thermistor_zone_fault == $past(thermistorZone)))
        else $error("cold or hot response wrong");
    AST_COOL: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
        (cool && !inputOvervoltage && !inputUndervoltage && !safetyTimerExpired
         && !chargeComplete) |=> (chargeCurrentHalved && thermistor_zone_fault == ZONE_COOL))
        else $error("cool response wrong");
    AST_WARM: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
        warm |=> (thermistor_zone_fault == ZONE_WARM && chargeState == CHG_FAULT))
        else $error("warm response wrong");
    AST_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
        (chargeComplete && !inputOvervoltage && !inputUndervoltage && !safetyTimerExpired)
        |=> (!chargerEnable && rechargeWatch && thermistorSenseEnable))
        else $error("done response wrong");
    AST_PULSE_SHAPE: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
        $rose(alertPulse) |-> alertPulse [*8])
        else $error("alert pulse too short");
    AST_PRIORITY: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
        (chargerEnable == 1'b0) |-> !(inputCurrentClamped || chargeCurrentHalved
                                      || regulationVoltageLowered || inputCurrentReduced))
        else $error("reduction shown while disabled");
endmodule

/* test_charger_fault_response_control.sv */
module test_charger_fault_response_control;
    timeunit 1ns;
    timeprecision 100ps;
    import charger_fault_pkg::*;
    // short pulse keeps the run brief
    localparam int PW = 10;
    logic sys_clk, rst_n, inputOvervoltage, inputUndervoltage, inputCurrentClamp;
    logic inputVoltageRegulation, safetyTimerExpired, chargeComplete;
    logic sysRailEnableCfg, loadOutputEnableCfg;
    logic [2:0] thermistorZone, thermistor_zone_fault;
    logic [1:0] chargeState;
    logic input_overvoltage_flag, input_undervoltage_flag, input_voltage_regulation_flag;
    logic safetyTimerFault, supply_ok_output, alertPulse, chargerEnable, inputCurrentClamped;
    logic inputCurrentReduced, chargeCurrentHalved, regulationVoltageLowered, rechargeWatch;
    logic thermistorSenseEnable, sysRailEnable, sysRailFromBattery;
    logic loadOutputEnable, loadOutputFromBattery;
    int alertCount, lastWidth, num_errors, cmp_count;
    logic [2:0] zl[4] = '{ZONE_COLD, ZONE_HOT, ZONE_COOL, ZONE_WARM};
    logic [3:0] zc[4] = '{4'h6, 4'h6, 4'hE, 4'hE};
    logic [3:0] zd[4] = '{4'h0, 4'h0, 4'h2, 4'h1};
    ////////////////////////////////////////////////////////////////
    charger_fault_response_control #(.PULSE_CYCLES(PW)) i_charger_fault_response_control (
        .sys_clk, .rst_n, .inputOvervoltage, .inputUndervoltage, .inputCurrentClamp,
        .inputVoltageRegulation, .safetyTimerExpired, .chargeComplete, .thermistorZone,
        .sysRailEnableCfg, .loadOutputEnableCfg, .chargeState, .input_overvoltage_flag,
        .input_undervoltage_flag, .input_voltage_regulation_flag, .safetyTimerFault,
        .thermistor_zone_fault, .supply_ok_output, .alertPulse, .chargerEnable,
        .inputCurrentClamped, .inputCurrentReduced, .chargeCurrentHalved,
        .regulationVoltageLowered, .rechargeWatch, .thermistorSenseEnable, .sysRailEnable,
        .sysRailFromBattery, .loadOutputEnable, .loadOutputFromBattery);
    alert_host_model i_alert_host_model (.sys_clk, .rst_n, .alertPulse, .alertCount,
        .lastWidth);
    ////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [3:0] expv, input logic [3:0] seen);
        cmp_count++;
        if (seen !== expv) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic chkInt(input string what, input int expv, input int seen);
        cmp_count++;
        if (seen != expv) begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", what, expv, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic apply(input logic [5:0] c, input logic [2:0] z);
        {inputOvervoltage, inputUndervoltage, inputCurrentClamp, inputVoltageRegulation,
            safetyTimerExpired, chargeComplete} = c;
        thermistorZone = z;
    endtask
    function automatic logic [3:0] rails();
        return {sysRailEnable, sysRailFromBattery, loadOutputEnable, loadOutputFromBattery};
    endfunction
    // one set of conditions from idle: control outputs one cycle on, then exactly one pulse
    task automatic scen(input logic [5:0] c, input logic [2:0] z, input logic [1:0] st,
        input logic [3:0] ctl);
        int n0;
        int k;
        apply(6'h00, ZONE_NORMAL);
        step(PW + 4);
        n0 = alertCount;
        apply(c, z);
        step(1);
        chk("state", st, chargeState);
        chk("ctrl", ctl, {chargerEnable, thermistorSenseEnable, supply_ok_output, rechargeWatch});
        k = 0;
        while (alertCount == n0 && k < PW + 6) begin
            step(1);
            k++;
        end
        chkInt("alerts", n0 + 1, alertCount);
        chkInt("width", PW, lastWidth);
        if (alertCount == n0) begin
            test_done();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        int n0;
        num_errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        sysRailEnableCfg = 1'b1;
        loadOutputEnableCfg = 1'b0;
        apply(6'h00, ZONE_NORMAL);
        step(20);
        chk("reset", 4'h0, {alertPulse, chargerEnable, supply_ok_output, rechargeWatch});
        rst_n = 1'b1;
        scen(6'h20, ZONE_NORMAL, CHG_FAULT, 4'h0);
        chk("ovflag", 4'h1, input_overvoltage_flag);
        chk("rails", 4'hF, rails());
        // swap the configured enables: a bad input must still force both rails on
        sysRailEnableCfg = 1'b0;
        loadOutputEnableCfg = 1'b1;
        scen(6'h10, ZONE_NORMAL, CHG_FAULT, 4'h0);
        chk("uvflag", 4'h1, input_undervoltage_flag);
        chk("rails", 4'hF, rails());
        scen(6'h08, ZONE_NORMAL, CHG_IN_PROGRESS, 4'hE);
        chk("clamp", 4'h1, inputCurrentClamped);
        chk("rails", 4'h2, rails());
        scen(6'h04, ZONE_NORMAL, CHG_FAULT, 4'hE);
        chk("vreg", 4'h3, {input_voltage_regulation_flag, inputCurrentReduced});
        scen(6'h02, ZONE_NORMAL, CHG_FAULT, 4'h2);
        chk("timer", 4'h1, safetyTimerFault);
        chk("rails", 4'h2, rails());
        foreach (zl[i]) begin
            scen(6'h00, zl[i], CHG_FAULT, zc[i]);
            chk("zone", zl[i], thermistor_zone_fault);
            chk("derate", zd[i], {chargeCurrentHalved, regulationVoltageLowered});
        end
        scen(6'h01, ZONE_NORMAL, CHG_DONE, 4'h7);
        scen(6'h02, ZONE_COOL, CHG_FAULT, 4'h2);
        chk("derate", 4'h0, {chargeCurrentHalved, regulationVoltageLowered});
        scen(6'h28, ZONE_NORMAL, CHG_FAULT, 4'h0);
        chk("clamp", 4'h0, inputCurrentClamped);
        // a second condition inside a running pulse must not stretch or repeat it
        apply(6'h00, ZONE_NORMAL);
        step(PW + 4);
        n0 = alertCount;
        apply(6'h20, ZONE_NORMAL);
        step(3);
        apply(6'h22, ZONE_NORMAL);
        step(PW + 8);
        chkInt("merged", n0 + 1, alertCount);
        chkInt("width", PW, lastWidth);
        test_done();
    end
endmodule
